// file: shared/arp_consts.vh
// Purpose: Register indices, field positions, reset values and counts of the result and
//          phase register bank.
// Assumes: Byte address of a register is four times its index.
// Notes:   Definitions only.
`ifndef ARP_CONSTS_VH
`define ARP_CONSTS_VH

`define ARP_IDX_W          6
`define ARP_IDX_CH0        6'h00
`define ARP_IDX_CH7        6'h07
`define ARP_IDX_MOD        6'h08
`define ARP_IDX_DLY_UP     6'h09
`define ARP_IDX_DLY_LO     6'h0a
`define ARP_IDX_CTRL       6'h10
`define ARP_IDX_STAT       6'h11
`define ARP_IDX_STREAM     6'h12

`define ARP_MOD_RESET      32'h33333333
`define ARP_DLY_RESET      24'h000000
`define ARP_RES_RESET      24'h000000
`define ARP_CTRL_RESET     7'h42

`define ARP_CTRL_LINK      0
`define ARP_CTRL_FMT_LO    1
`define ARP_CTRL_FMT_HI    2
`define ARP_CTRL_OFFS      3
`define ARP_CTRL_GAIN      4
`define ARP_CTRL_INC_LO    5
`define ARP_CTRL_INC_HI    6

`define ARP_FMT_32SIGN     2'h3
`define ARP_FMT_32PAD      2'h2
`define ARP_FMT_24         2'h1
`define ARP_FMT_16RND      2'h0

`define ARP_INC_MAP        2'h3
`define ARP_INC_TYPES      2'h2
`define ARP_INC_GROUPS     2'h1
`define ARP_INC_NONE       2'h0

`define ARP_DLY_HI_LSB     12
`define ARP_DLY_W          12
`define ARP_GAIN_DELAY     5'h18
`define ARP_GAIN_FRAC      23

`define ARP_RESP_OKAY      2'h0
`define ARP_RESP_SLVERR    2'h2

`endif

// file: logic/arp_result_phase_regs.v
// Purpose: Eight channel result registers, modulator snapshot and phase delay registers,
//          reached over AXI4-Lite.
// Assumes: Converter core runs on clk_sys_in; mod_tick_in is a one-cycle enable per
//          modulator clock period; conversion inputs are on the same clock.
// Notes:   Control bits for ready link, format, corrections and read stepping sit in a
//          control register of this block.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "arp_consts.vh"

module arp_result_phase_regs #(
  parameter ADDR_W = 8,
  parameter LAST_IDX = 6'h0a
) (
  input  wire           clk_sys_in,
  input  wire           reset_in,
  input  wire [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire           s_axi_awvalid_in,
  output wire           s_axi_awready_out,
  input  wire [31:0]    s_axi_wdata_in,
  input  wire [3:0]     s_axi_wstrb_in,
  input  wire           s_axi_wvalid_in,
  output wire           s_axi_wready_out,
  output wire [1:0]     s_axi_bresp_out,
  output wire           s_axi_bvalid_out,
  input  wire           s_axi_bready_in,
  input  wire [ADDR_W-1:0] s_axi_araddr_in,
  input  wire           s_axi_arvalid_in,
  output wire           s_axi_arready_out,
  output wire [31:0]    s_axi_rdata_out,
  output wire [1:0]     s_axi_rresp_out,
  output wire           s_axi_rvalid_out,
  input  wire           s_axi_rready_in,
  input  wire           mod_tick_in,
  input  wire [31:0]    mod_bits_in,
  input  wire [191:0]   channel_code_in,
  input  wire [7:0]     conv_done_in,
  input  wire [191:0]   offset_cal_in,
  input  wire [191:0]   gain_cal_in,
  output wire           data_ready_pin_out,
  output wire [7:0]     channel_ready_out,
  output wire           conv_restart_out,
  output wire [7:0]     channel_start_out
);

  reg  [23:0] stage_ff  [0:7];
  reg  [23:0] result_ff [0:7];
  reg  [4:0]  gdly_ff   [0:7];
  reg  [7:0]  gpend_ff;
  reg  [7:0]  emit_ff;
  reg  [7:0]  link_pend_ff;
  reg         drdy_ff;
  reg  [31:0] mod_snap_ff;
  reg  [23:0] dly_up_ff;
  reg  [23:0] dly_lo_ff;
  reg  [6:0]  ctrl_ff;
  reg  [5:0]  ptr_ff;
  reg         restart_ff;
  reg  [7:0]  start_ff;
  reg  [11:0] pcnt_ff   [0:3];
  reg  [3:0]  prun_ff;
  reg         aw_got_ff;
  reg  [ADDR_W-1:0] awaddr_ff;
  reg         w_got_ff;
  reg  [31:0] wdata_ff;
  reg  [3:0]  wstrb_ff;
  reg         bvalid_ff;
  reg  [1:0]  bresp_ff;
  reg         rvalid_ff;
  reg  [31:0] rdata_ff;
  reg  [1:0]  rresp_ff;

  wire        link_on  = ctrl_ff[`ARP_CTRL_LINK];
  wire [1:0]  fmt      = ctrl_ff[`ARP_CTRL_FMT_HI:`ARP_CTRL_FMT_LO];
  wire        offs_on  = ctrl_ff[`ARP_CTRL_OFFS];
  wire        gain_on  = ctrl_ff[`ARP_CTRL_GAIN];
  wire [1:0]  inc_mode = ctrl_ff[`ARP_CTRL_INC_HI:`ARP_CTRL_INC_LO];
  wire [23:0] corr_w   [0:7];
  wire [7:0]  emit_now;
  wire [7:0]  link_all = link_pend_ff | emit_now;

  function [23:0] sat24;
    input [24:0] v;
    begin
      if (v[24] != v[23])
        sat24 = v[24] ? 24'h800000 : 24'h7fffff;
      else
        sat24 = v[23:0];
    end
  endfunction

  // Sixteen-bit mode rounds half up and saturates at the positive end.
  function [31:0] fmt_word;
    input [23:0] d;
    input [1:0]  f;
    reg   [16:0] r;
    begin
      r = {d[23], d[23:8]} + {16'h0000, d[7]};
      case (f)
        `ARP_FMT_32SIGN: fmt_word = {{8{d[23]}}, d};
        `ARP_FMT_32PAD:  fmt_word = {d, 8'h00};
        `ARP_FMT_24:     fmt_word = {8'h00, d};
        default: begin
          if (r[16] != r[15])
            fmt_word = {16'h0000, 16'h7fff};
          else
            fmt_word = {16'h0000, r[15:0]};
        end
      endcase
    end
  endfunction

  function [31:0] reg_word;
    input [5:0] idx;
    begin
      if (idx <= `ARP_IDX_CH7)
        reg_word = fmt_word(result_ff[idx[2:0]], fmt);
      else if (idx == `ARP_IDX_MOD)
        reg_word = mod_snap_ff;
      else if (idx == `ARP_IDX_DLY_UP)
        reg_word = {8'h00, dly_up_ff};
      else if (idx == `ARP_IDX_DLY_LO)
        reg_word = {8'h00, dly_lo_ff};
      else if (idx == `ARP_IDX_CTRL)
        reg_word = {25'h0000000, ctrl_ff};
      else if (idx == `ARP_IDX_STAT)
        reg_word = {18'h00000, ptr_ff, gpend_ff};
      else
        reg_word = 32'h00000000;
    end
  endfunction

  function idx_ok;
    input [5:0] idx;
    begin
      idx_ok = (idx <= LAST_IDX) || (idx == `ARP_IDX_CTRL) ||
               (idx == `ARP_IDX_STAT) || (idx == `ARP_IDX_STREAM);
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (be[k])
          merge[8*k +: 8] = nw[8*k +: 8];
    end
  endfunction

  // Next stream pointer: types loop channels apart from the rest, groups loop channels in pairs and the rest as types do.
  function [5:0] next_ptr;
    input [5:0] p;
    input [1:0] m;
    begin
      case (m)
        `ARP_INC_MAP:
          next_ptr = (p >= LAST_IDX) ? 6'h00 : p + 6'h01;
        `ARP_INC_TYPES:
          if (p <= `ARP_IDX_CH7)
            next_ptr = (p == `ARP_IDX_CH7) ? 6'h00 : p + 6'h01;
          else
            next_ptr = (p >= LAST_IDX) ? `ARP_IDX_MOD : p + 6'h01;
        `ARP_INC_GROUPS:
          if (p <= `ARP_IDX_CH7)
            next_ptr = {p[5:1], ~p[0]};
          else
            next_ptr = (p >= LAST_IDX) ? `ARP_IDX_MOD : p + 6'h01;
        default:
          next_ptr = p;
      endcase
    end
  endfunction

  // Correction and gain group delay, one lane per channel.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_ch
      wire signed [23:0] raw  = channel_code_in[24*gi +: 24];
      wire signed [23:0] ofs  = offset_cal_in[24*gi +: 24];
      wire signed [23:0] gcf  = gain_cal_in[24*gi +: 24];
      wire        [23:0] aofs = offs_on ? sat24({raw[23], raw} + {ofs[23], ofs}) : raw;
      wire signed [47:0] prod = $signed(aofs) * gcf;
      wire        [24:0] gsum = {aofs[23], aofs} + prod[`ARP_GAIN_FRAC+24:`ARP_GAIN_FRAC];
      assign corr_w[gi]   = gain_on ? sat24(gsum) : aofs;
      assign emit_now[gi] = gpend_ff[gi] && (gdly_ff[gi] == 5'h00);

      always @(posedge clk_sys_in) begin
        if (reset_in) begin
          stage_ff[gi]  <= `ARP_RES_RESET;
          result_ff[gi] <= `ARP_RES_RESET;
          gdly_ff[gi]   <= 5'h00;
          gpend_ff[gi]  <= 1'b0;
        end else begin
          if (conv_done_in[gi]) begin
            stage_ff[gi] <= corr_w[gi];
            gdly_ff[gi]  <= gain_on ? `ARP_GAIN_DELAY : 5'h00;
            gpend_ff[gi] <= 1'b1;
          end else if (emit_now[gi]) begin
            gpend_ff[gi] <= 1'b0;
          end else if (gpend_ff[gi] && mod_tick_in) begin
            gdly_ff[gi] <= gdly_ff[gi] - 5'h01;
          end
          // A read takes its copy at address acceptance, so updates here never tear it.
          if (link_on ? (link_all == 8'hff) : emit_now[gi])
            result_ff[gi] <= stage_ff[gi];
        end
      end
    end
  endgenerate

  always @(posedge clk_sys_in) begin
    if (reset_in) begin
      link_pend_ff <= 8'h00;
      emit_ff      <= 8'h00;
      drdy_ff      <= 1'b0;
    end else begin
      if (!link_on || link_all == 8'hff)
        link_pend_ff <= 8'h00;
      else
        link_pend_ff <= link_all;
      emit_ff <= link_on ? {8{link_all == 8'hff}} : emit_now;
      drdy_ff <= link_on ? (link_all == 8'hff) : (emit_now != 8'h00);
    end
  end

  // Bus side.
  wire [5:0] aw_idx  = awaddr_ff[ADDR_W-1:2];
  wire [5:0] ar_idx  = s_axi_araddr_in[ADDR_W-1:2];
  wire       do_wr   = aw_got_ff && w_got_ff && !bvalid_ff;
  wire       do_rd   = s_axi_arvalid_in && !rvalid_ff;
  wire [31:0] mod_nw = merge(mod_snap_ff, wdata_ff, wstrb_ff);
  wire [31:0] up_nw  = merge({8'h00, dly_up_ff}, wdata_ff, wstrb_ff);
  wire [31:0] lo_nw  = merge({8'h00, dly_lo_ff}, wdata_ff, wstrb_ff);
  wire [31:0] ctl_nw = merge({25'h0000000, ctrl_ff}, wdata_ff, wstrb_ff);
  wire [31:0] ptr_nw = merge({26'h0000000, ptr_ff}, wdata_ff, wstrb_ff);

  assign s_axi_awready_out = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready_out  = !w_got_ff && !bvalid_ff;
  assign s_axi_bvalid_out  = bvalid_ff;
  assign s_axi_bresp_out   = bresp_ff;
  assign s_axi_arready_out = !rvalid_ff;
  assign s_axi_rvalid_out  = rvalid_ff;
  assign s_axi_rdata_out   = rdata_ff;
  assign s_axi_rresp_out   = rresp_ff;

  always @(posedge clk_sys_in) begin
    if (reset_in) begin
      aw_got_ff   <= 1'b0;
      awaddr_ff   <= {ADDR_W{1'b0}};
      w_got_ff    <= 1'b0;
      wdata_ff    <= 32'h00000000;
      wstrb_ff    <= 4'h0;
      bvalid_ff   <= 1'b0;
      bresp_ff    <= `ARP_RESP_OKAY;
      rvalid_ff   <= 1'b0;
      rdata_ff    <= 32'h00000000;
      rresp_ff    <= `ARP_RESP_OKAY;
      mod_snap_ff <= `ARP_MOD_RESET;
      dly_up_ff   <= `ARP_DLY_RESET;
      dly_lo_ff   <= `ARP_DLY_RESET;
      ctrl_ff     <= `ARP_CTRL_RESET;
      ptr_ff      <= 6'h00;
      restart_ff  <= 1'b0;
    end else begin
      restart_ff <= 1'b0;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata_in;
        wstrb_ff <= s_axi_wstrb_in;
      end
      if (bvalid_ff && s_axi_bready_in)
        bvalid_ff <= 1'b0;
      // Each comparator nibble is copied straight; a host write only lasts until the tick.
      if (mod_tick_in)
        mod_snap_ff <= mod_bits_in;
      if (do_wr) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= idx_ok(aw_idx) ? `ARP_RESP_OKAY : `ARP_RESP_SLVERR;
        // Result registers take no write; the access is answered and dropped.
        if (aw_idx == `ARP_IDX_MOD && !mod_tick_in)
          mod_snap_ff <= mod_nw;
        if (aw_idx == `ARP_IDX_DLY_UP) begin
          dly_up_ff  <= up_nw[23:0];
          restart_ff <= 1'b1;
        end
        if (aw_idx == `ARP_IDX_DLY_LO) begin
          dly_lo_ff  <= lo_nw[23:0];
          restart_ff <= 1'b1;
        end
        if (aw_idx == `ARP_IDX_CTRL)
          ctrl_ff <= ctl_nw[6:0];
        if (aw_idx == `ARP_IDX_STREAM)
          ptr_ff <= ptr_nw[5:0];
      end
      if (rvalid_ff && s_axi_rready_in)
        rvalid_ff <= 1'b0;
      if (do_rd) begin
        rvalid_ff <= 1'b1;
        rresp_ff  <= idx_ok(ar_idx) ? `ARP_RESP_OKAY : `ARP_RESP_SLVERR;
        if (ar_idx == `ARP_IDX_STREAM) begin
          rdata_ff <= reg_word(ptr_ff);
          ptr_ff   <= next_ptr(ptr_ff, inc_mode);
        end else begin
          rdata_ff <= reg_word(ar_idx);
        end
      end
    end
  end

  // Phase delay: the odd channel of each pair is the reference and starts at restart.
  wire [11:0] pcode [0:3];
  assign pcode[0] = dly_lo_ff[`ARP_DLY_W-1:0];
  assign pcode[1] = dly_lo_ff[`ARP_DLY_HI_LSB +: `ARP_DLY_W];
  assign pcode[2] = dly_up_ff[`ARP_DLY_W-1:0];
  assign pcode[3] = dly_up_ff[`ARP_DLY_HI_LSB +: `ARP_DLY_W];

  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pair
      always @(posedge clk_sys_in) begin
        if (reset_in) begin
          pcnt_ff[gi]      <= 12'h000;
          prun_ff[gi]      <= 1'b0;
          start_ff[2*gi]   <= 1'b0;
          start_ff[2*gi+1] <= 1'b0;
        end else begin
          start_ff[2*gi+1] <= restart_ff;
          start_ff[2*gi]   <= 1'b0;
          if (restart_ff) begin
            pcnt_ff[gi] <= pcode[gi];
            prun_ff[gi] <= (pcode[gi] != 12'h000);
            start_ff[2*gi] <= (pcode[gi] == 12'h000);
          end else if (prun_ff[gi] && mod_tick_in) begin
            pcnt_ff[gi] <= pcnt_ff[gi] - 12'h001;
            if (pcnt_ff[gi] == 12'h001) begin
              prun_ff[gi]    <= 1'b0;
              start_ff[2*gi] <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  assign conv_restart_out   = restart_ff;
  assign channel_start_out  = start_ff;
  assign channel_ready_out  = emit_ff;
  assign data_ready_pin_out = drdy_ff;

endmodule // arp_result_phase_regs

// file: testbench/arp_checker.sv
// Purpose: Port timing checks for the result and phase register bank.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes:   Attached to every bank instance by the bind at the foot.
`timescale 1ns/100ps
`include "arp_consts.vh"
module arp_checker #(
  parameter ADDR_W = 8
) (
  input wire logic              clk_sys_in,
  input wire logic              reset_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic              s_axi_awvalid_in,
  input wire logic              s_axi_awready_out,
  input wire logic              s_axi_wvalid_in,
  input wire logic              s_axi_wready_out,
  input wire logic [1:0]        s_axi_bresp_out,
  input wire logic              s_axi_bvalid_out,
  input wire logic              s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic              s_axi_arvalid_in,
  input wire logic              s_axi_arready_out,
  input wire logic [31:0]       s_axi_rdata_out,
  input wire logic [1:0]        s_axi_rresp_out,
  input wire logic              s_axi_rvalid_out,
  input wire logic              s_axi_rready_in,
  input wire logic              data_ready_pin_out,
  input wire logic [7:0]        channel_ready_out,
  input wire logic              conv_restart_out,
  input wire logic [7:0]        channel_start_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  wire w_hs = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  wire r_hs = s_axi_arvalid_in && s_axi_arready_out;
  property p_rdata_hold;
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read word changed");
  property p_ar_block; r_hs |=> s_axi_rvalid_out && !s_axi_arready_out; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  property p_b_hold;
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_ro_okay;
    w_hs && s_axi_awaddr_in[7:2] <= 6'h07 |-> ##2 s_axi_bvalid_out
      && s_axi_bresp_out == `ARP_RESP_OKAY;
  endproperty
  a_ro_okay: assert property (p_ro_okay) else $error("result write answer wrong");
  property p_restart;
    w_hs && (s_axi_awaddr_in[7:2] == 6'h09 || s_axi_awaddr_in[7:2] == 6'h0a)
      |-> ##[1:4] conv_restart_out;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart after delay write");
  property p_odd_start;
    conv_restart_out |=> !conv_restart_out && (channel_start_out & 8'haa) == 8'haa;
  endproperty
  a_odd_start: assert property (p_odd_start) else $error("reference starts missing");
  property p_pin; data_ready_pin_out == (channel_ready_out != 8'h00); endproperty
  a_pin: assert property (p_pin) else $error("ready pin and channel pulses differ");
  property p_rd_okay;
    r_hs && s_axi_araddr_in[7:2] <= 6'h0a |=> s_axi_rresp_out == `ARP_RESP_OKAY;
  endproperty
  a_rd_okay: assert property (p_rd_okay) else $error("mapped read refused");
endmodule // arp_checker

bind arp_result_phase_regs arp_checker #(.ADDR_W(ADDR_W)) i_chk (
  .clk_sys_in, .reset_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
  .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
  .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
  .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
  .data_ready_pin_out, .channel_ready_out, .conv_restart_out, .channel_start_out
);

// file: testbench/arp_conv_model.sv
// Purpose: Converter core stand-in driving ticks, comparator bits and results.
// Assumes: The bench asks for a conversion one cycle ahead on done_req_in.
// Notes:   Result lines toggle outside the done cycle, so a late capture shows up.
`timescale 1ns/100ps
module arp_conv_model (
  input  wire logic         clk_sys_in,
  input  wire logic         tick_en_in,
  input  wire logic [7:0]   done_req_in,
  input  wire logic [191:0] code_req_in,
  output logic              mod_tick_out,
  output logic [31:0]       mod_bits_out,
  output logic [191:0]      channel_code_out,
  output logic [7:0]        conv_done_out
);
  logic [1:0] div_ff = 2'h0;
  initial begin
    mod_tick_out = 1'b0;
    mod_bits_out = 32'h33333333;
    channel_code_out = '0;
    conv_done_out = 8'h00;
  end
  always @(posedge clk_sys_in) begin
    div_ff <= div_ff + 2'h1;
    mod_tick_out <= tick_en_in && div_ff == 2'h3;
    if (tick_en_in && div_ff == 2'h3) begin
      mod_bits_out <= {mod_bits_out[30:0], mod_bits_out[31] ^ mod_bits_out[21]};
    end
    conv_done_out <= done_req_in;
    channel_code_out <= (done_req_in != 8'h00) ? code_req_in : ~channel_code_out;
  end
endmodule // arp_conv_model

// file: testbench/arp_result_phase_regs_tb.sv
// Purpose: Self-checking bench for the result and phase register bank.
// Assumes: The converter stand-in ticks every four cycles while enabled.
// Notes:   A bench table of channel codes predicts every result word read back after the first conversion.
`timescale 1ns/100ps
`include "arp_consts.vh"
module arp_result_phase_regs_tb;
  logic         clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0, rre = 1'b1;
  logic         ten = 1'b0, awr, wrd, bv, arr, rv, tk, drp, rs;
  logic [7:0]   awa = 8'h00, ara = 8'h00, dq = 8'h00, cd, cr, cs;
  logic [31:0]  wd = 32'h0, mb, rdat, v;
  logic [191:0] cq = '0, ofs = '0, gns = '0, cc;
  logic [1:0]   br, rr;
  logic [23:0]  ex [8];
  int           fail_count = 0, samples_checked = 0, dr_cnt = 0, tc = 0, lag [4];
  always #2 clk = ~clk;
  arp_result_phase_regs i_dut (
    .clk_sys_in(clk), .reset_in(rst), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd), .s_axi_bresp_out(br),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(1'b1), .s_axi_araddr_in(ara),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdat),
    .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre), .mod_tick_in(tk),
    .mod_bits_in(mb), .channel_code_in(cc), .conv_done_in(cd), .offset_cal_in(ofs),
    .gain_cal_in(gns), .data_ready_pin_out(drp), .channel_ready_out(cr),
    .conv_restart_out(rs), .channel_start_out(cs));
  arp_conv_model i_conv (
    .clk_sys_in(clk), .tick_en_in(ten), .done_req_in(dq), .code_req_in(cq),
    .mod_tick_out(tk), .mod_bits_out(mb), .channel_code_out(cc), .conv_done_out(cd));
  // Ticks count from the edge that shows the reference start, so each lag is in
  // modulator periods; a tick on that same edge already counts towards the delay.
  always @(posedge clk) begin
    if (drp === 1'b1) dr_cnt++;
    if ((cs & 8'haa) != 8'h00) tc = 0;
    for (int j = 0; j < 4; j++) if (cs[2*j] === 1'b1) lag[j] = tc;
    if (tk === 1'b1) tc++;
  end
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] i, input logic [31:0] d, input logic [1:0] e);
    int n;
    n = 0;
    awa <= {i, 2'b00};
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
    end while (!bv && n < 99);
    chk({br, 32'h0}, {e, 32'h0});
    if (n >= 99) begin fail_count++; print_verdict; end
  endtask
  task automatic rd(input logic [5:0] i, input int st, output logic [33:0] q);
    int n;
    n = 0;
    ara <= {i, 2'b00};
    arv <= 1'b1;
    if (st > 0) rre <= 1'b0;
    do begin
      @(posedge clk);
      n++;
      if (arv && arr) arv <= 1'b0;
      if (n > st) rre <= 1'b1;
    end while (!(rre && rv) && n < 99);
    q = {rr, rdat};
    if (n >= 99) begin fail_count++; print_verdict; end
  endtask
  task automatic rchk(input logic [5:0] i, input logic [31:0] e);
    logic [33:0] q;
    rd(i, 0, q);
    chk(q, {`ARP_RESP_OKAY, e});
  endtask
  task automatic conv(input logic [7:0] m, input logic [31:0] msk);
    logic [31:0] c;
    for (int k = 0; k < 8; k++) begin
      c = $urandom & msk;
      cq[24*k +: 24] <= c[23:0];
      if (m[k]) ex[k] = c[23:0];
    end
    dq <= m;
    @(posedge clk);
    dq <= 8'h00;
    // With the gain correction off, returning only after the commit and the counted ready
    // pulse keeps a following read from racing the result update.
    repeat (4) @(posedge clk);
  endtask
  function automatic logic [31:0] fmtv(input logic [23:0] d, input logic [1:0] f);
    int s;
    s = ($signed(d) + 128) >>> 8;
    if (s > 32767) s = 32767;
    case (f)
      `ARP_FMT_32SIGN: return {{8{d[23]}}, d};
      `ARP_FMT_32PAD: return {d, 8'h00};
      `ARP_FMT_24: return {8'h00, d};
      default: return {16'h0000, s[15:0]};
    endcase
  endfunction
  function automatic logic [31:0] ev(input int i);
    return (i < 8) ? {8'h00, ex[i]} : v;
  endfunction
  initial begin
    logic [33:0] q;
    logic [1:0]  f;
    int          j0, sq [4][3];
    longint      x;
    void'($urandom(58));
    sq = '{'{6, 6, 6}, '{6, 7, 6}, '{6, 7, 0}, '{6, 7, 8}};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 11; i++) rchk(6'(i), (i == 8) ? `ARP_MOD_RESET : 32'h0);
    rd(6'h20, 0, q);
    chk(q, {`ARP_RESP_SLVERR, 32'h0});
    wr(6'h20, $urandom, `ARP_RESP_SLVERR);
    wr(6'h03, $urandom, `ARP_RESP_OKAY);
    rchk(6'h03, 32'h0);
    conv(8'hff, 32'hffffff);
    for (int i = 0; i < 8; i++) rchk(6'(i), ev(i));
    v = ev(0);
    @(posedge clk);
    fork
      rd(6'h00, 8, q);
      begin repeat (2) @(posedge clk); conv(8'h01, 32'hffffff); end
    join
    chk(q, {`ARP_RESP_OKAY, v});
    rchk(6'h00, ev(0));
    for (int j = 0; j < 4; j++) begin
      f = 2'(j + 2);
      wr(`ARP_IDX_CTRL, {25'h0, 2'b10, 2'b00, f, 1'b0}, `ARP_RESP_OKAY);
      rchk(6'h00, fmtv(ex[0], f));
    end
    wr(`ARP_IDX_CTRL, 32'h43, `ARP_RESP_OKAY);
    conv(8'hff, 32'hffffff);
    v = ev(0);
    j0 = dr_cnt;
    for (int i = 0; i < 7; i++) conv(8'h01 << i, 32'hffffff);
    rchk(6'h00, v);
    conv(8'h80, 32'hffffff);
    for (int i = 0; i < 8; i++) rchk(6'(i), ev(i));
    chk(34'(dr_cnt - j0), 34'd1);
    for (int k = 0; k < 8; k++) begin
      ofs[24*k +: 24] <= 24'($urandom & 32'hffff);
      gns[24*k +: 24] <= 24'($urandom & 32'hfffff);
    end
    ten <= 1'b1;
    wr(`ARP_IDX_CTRL, 32'h5a, `ARP_RESP_OKAY);
    v = ev(1);
    conv(8'hff, 32'hfffff);
    repeat (40) @(posedge clk);
    rchk(6'h01, v);
    repeat (80) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      x = ex[k] + ofs[24*k +: 24];
      x = x + ((x * gns[24*k +: 24]) >>> 23);
      ex[k] = 24'(x);
      rchk(6'(k), ev(k));
    end
    wr(`ARP_IDX_CTRL, 32'h42, `ARP_RESP_OKAY);
    for (int k = 9; k < 11; k++) begin
      v = $urandom;
      wr(6'(k), v, `ARP_RESP_OKAY);
      rchk(6'(k), {8'h00, v[23:0]});
    end
    lag = '{-1, -1, -1, -1};
    wr(`ARP_IDX_DLY_UP, {8'h00, 12'd0, 12'd3}, `ARP_RESP_OKAY);
    wr(`ARP_IDX_DLY_LO, {8'h00, 12'd5, 12'd1}, `ARP_RESP_OKAY);
    repeat (40) @(posedge clk);
    chk(34'(lag[3]), 34'd0);
    chk(34'(lag[2]), 34'd3);
    chk(34'(lag[1]), 34'd5);
    chk(34'(lag[0]), 34'd1);
    // The snapshot is never written here; a write would only change the read word, no output.
    ten <= 1'b0;
    conv(8'hff, 32'hffffff);
    repeat (8) @(posedge clk);
    v = mb;
    rchk(`ARP_IDX_MOD, v);
    for (int m = 0; m < 4; m++) begin
      wr(`ARP_IDX_CTRL, {25'h0, 2'(m), 4'h1, 1'b0}, `ARP_RESP_OKAY);
      wr(`ARP_IDX_STREAM, 32'h6, `ARP_RESP_OKAY);
      for (int n = 0; n < 3; n++) rchk(`ARP_IDX_STREAM, ev(sq[m][n]));
    end
    rchk(`ARP_IDX_STAT, 32'h00000900);
    rchk(`ARP_IDX_CTRL, 32'h00000062);
    print_verdict;
  end
endmodule // arp_result_phase_regs_tb
